/* bench/crc16_byte_checksum_unit_test.sv */
`timescale 1ns/1ps
module crc16_byte_checksum_unit_test;
  logic        clk = 0, rst = 1, rd = 0, wr = 0, wt;
  logic [3:0]  adr = 4'h0, be = 4'hF;
  logic [31:0] wd = 32'h0, rdo, got;
  logic [15:0] sum;
  int          bad_count = 0, checked = 0;
  logic [15:0] tab [8] = '{16'hFF9F, 16'hBBC3, 16'hA367, 16'hD0FA,
                           16'h0110, 16'h91F1, 16'hF2DE, 16'h5C43};
  crc16_byte_checksum_unit dut (.CORE_CLK_IN(clk), .RESET_IN(rst), .AVS_ADDRESS_IN(adr),
    .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd), .AVS_BYTEENABLE_IN(be),
    .AVS_READDATA_OUT(rdo), .AVS_WAITREQUEST_OUT(wt), .CRC_SUM_OUT(sum));
  initial forever #2 clk = ~clk;
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    {adr, wr, rd, wd} <= {a, w, !w, 24'h0, d};
    do @(posedge clk); while (wt !== 1'b0);
    got = rdo;
    {wr, rd} <= 2'b00;
    @(posedge clk);
  endtask
  task chk(input logic [3:0] a, input logic [31:0] e);
    bus(0, a, 8'h0);
    checked++;
    bad_count += (got !== e);
    if (got !== e) $display("MISMATCH reg %h expected %h seen %h", a, e, got);
  endtask
  task chk_sum(input logic [15:0] e);
    checked++;
    bad_count += (sum !== e);
    if (sum !== e) $display("MISMATCH sum expected %h seen %h", e, sum);
  endtask
  task t_regs;
    for (int i = 0; i < 5; i++) chk(i[3:0], 0);
    for (int i = 0; i < 4; i++) bus(1, i[3:0], 8'h3D + 8'h40 * i[7:0]);
    for (int i = 0; i < 3; i++) chk(i[3:0], 8'h3D + 8'h40 * i[7:0]);
    chk(4'h3, 1);
    chk(4'h4, 32'hBD7D);
    chk_sum(16'hBD7D);
    be <= 4'hE;
    bus(1, 4'h1, 8'h11);
    be <= 4'hF;
    chk(4'h1, 32'h7D);
    bus(1, 4'h9, 8'h77);
    chk(4'h9, 0);
  endtask
  task t_chain;
    for (int p = 0; p < 2; p++) begin
      bus(1, 4'h3, {7'h0, p[0]});
      // First pass runs the bytes back to back, second checks every step
      for (int r = 0; r < 2; r++) begin
        for (int c = 1; c < 3; c++) bus(1, c[3:0], 8'h0);
        for (int k = 0; k < 4; k++) begin
          bus(1, 4'h0, 8'h78 - 8'h22 * k[7:0]);
          chk_sum(tab[p * 4 + k]);
          if (r == 1 || k == 3) chk(4'h4, tab[p * 4 + k]);
        end
      end
    end
  endtask
  task final_report;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 0;
    t_regs;
    t_chain;
    final_report;
  end
  initial begin
    #3000 bad_count++;
    final_report;
  end
endmodule

/* bench/crc_unit_asserts.sv */
`timescale 1ns/1ps
module crc_unit_asserts (
  input logic        CORE_CLK_IN,
  input logic        RESET_IN,
  input logic [3:0]  AVS_ADDRESS_IN,
  input logic        AVS_READ_IN,
  input logic        AVS_WRITE_IN,
  input logic [31:0] AVS_WRITEDATA_IN,
  input logic [3:0]  AVS_BYTEENABLE_IN,
  input logic [31:0] AVS_READDATA_OUT,
  input logic        AVS_WAITREQUEST_OUT,
  input logic [15:0] CRC_SUM_OUT);
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (RESET_IN);
  wire       wt = AVS_WAITREQUEST_OUT;
  wire       sn = wt & (AVS_READ_IN | AVS_WRITE_IN);
  wire       ws = !wt & AVS_WRITE_IN & AVS_BYTEENABLE_IN[0];
  wire [3:0] a  = AVS_ADDRESS_IN;
  a_fast_answer: assert property (sn |=> !wt) else $error("slow");
  a_short_answer: assert property (!wt |=> wt) else $error("long");
  a_answer_cause: assert property (!wt |-> $past(sn)) else $error("stray");
  a_sum_cause: assert property ($changed(CRC_SUM_OUT) |-> $past(ws)) else $error("sum");
  a_low_store: assert property (
    ws && a == 1 |=> CRC_SUM_OUT[7:0] == $past(AVS_WRITEDATA_IN[7:0])) else $error("low");
  a_high_store: assert property (
    ws && a == 2 |=> CRC_SUM_OUT[15:8] == $past(AVS_WRITEDATA_IN[7:0])) else $error("high");
  a_sum_kept: assert property (ws && a > 2 |=> $stable(CRC_SUM_OUT)) else $error("kept");
  a_ctrl_upper: assert property (
    sn && AVS_READ_IN && a == 3 |=> AVS_READDATA_OUT[31:1] == 0) else $error("ctrl");
endmodule
bind crc16_byte_checksum_unit crc_unit_asserts u_chk (.*);

/* src/crc16_byte_checksum_unit.v */
// Local design decisions: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`include "crc_unit_defines.vh"

// Functional notes
// - Select bit 0 CCITT, 1 CRC-16; resets 0
// - Only two fixed polynomials, none programmable
// - Each input byte write updates checksum pair
// - One byte per write, single cycle
// - XOR byte into checksum high byte
// - Shift left inserting zero each step
// - XOR polynomial when bit leaving set
// - Eight steps; result chains to next
// - High byte holds bits 15..8, RW
// - Low byte holds bits 7..0, RW
// - Control upper 31 bits read zero
// - Input register eight bits, RW, resets zero
module crc16_byte_checksum_unit (
  input  wire        CORE_CLK_IN,
  input  wire        RESET_IN,
  input  wire [3:0]  AVS_ADDRESS_IN,
  input  wire        AVS_READ_IN,
  input  wire        AVS_WRITE_IN,
  input  wire [31:0] AVS_WRITEDATA_IN,
  input  wire [3:0]  AVS_BYTEENABLE_IN,
  output reg  [31:0] AVS_READDATA_OUT,
  output reg         AVS_WAITREQUEST_OUT,
  output reg  [15:0] CRC_SUM_OUT
);

  reg  [7:0]  byte_input_q;
  reg  [15:0] crc_running_sum_q;
  reg  [15:0] crc_running_sum_d;
  reg         select_a_q;
  reg  [31:0] read_data_d;
  reg         served_q;
  wire [15:0] next_sum;
  wire        req;
  wire        wr_go;
  wire        rd_go;
  wire        lane0;

  // Each request waits one cycle, then completes with waitrequest low
  // Writes commit at that completing edge, reads capture on the first
  assign req   = AVS_READ_IN | AVS_WRITE_IN;
  assign wr_go = AVS_WRITE_IN & served_q;
  assign rd_go = AVS_READ_IN & ~served_q;
  assign lane0 = AVS_BYTEENABLE_IN[0];

  crc_byte_step u_step (
    .sum_in      (crc_running_sum_q),
    .data_in     (AVS_WRITEDATA_IN[7:0]),
    .select_a_in (select_a_q),
    .sum_out     (next_sum)
  );

  always @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      AVS_WAITREQUEST_OUT <= 1'b1;
      served_q            <= 1'b0;
    end else begin
      served_q            <= req & ~served_q;
      AVS_WAITREQUEST_OUT <= ~(req & ~served_q);
    end
  end

  // Next checksum shared by the register and the output port
  always @* begin
    crc_running_sum_d = crc_running_sum_q;
    if (wr_go && lane0) begin
      case (AVS_ADDRESS_IN)
        `CRC_ADDR_BYTE_INPUT: begin
          crc_running_sum_d = next_sum;
        end
        `CRC_ADDR_SUM_LOW: begin
          crc_running_sum_d[7:0] = AVS_WRITEDATA_IN[7:0];
        end
        `CRC_ADDR_SUM_HIGH: begin
          crc_running_sum_d[15:8] = AVS_WRITEDATA_IN[7:0];
        end
        default: begin
          crc_running_sum_d = crc_running_sum_q;
        end
      endcase
    end
  end

  always @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      byte_input_q      <= `CRC_BYTE_RESET;
      crc_running_sum_q <= `CRC_SUM_RESET;
      select_a_q        <= `CRC_SELECT_A_SEL_RESET;
    end else begin
      crc_running_sum_q <= crc_running_sum_d;
      if (wr_go && lane0) begin
        case (AVS_ADDRESS_IN)
          `CRC_ADDR_BYTE_INPUT: begin
            byte_input_q <= AVS_WRITEDATA_IN[7:0];
          end
          `CRC_ADDR_SELECT_A_CTRL: begin
            select_a_q <= AVS_WRITEDATA_IN[`CRC_SELECT_A_SEL_BIT];
          end
          default: begin
            select_a_q <= select_a_q;
          end
        endcase
      end
    end
  end

  always @* begin
    case (AVS_ADDRESS_IN)
      `CRC_ADDR_BYTE_INPUT: read_data_d = {24'h000000, byte_input_q};
      `CRC_ADDR_SUM_LOW:    read_data_d = {24'h000000, crc_running_sum_q[7:0]};
      `CRC_ADDR_SUM_HIGH:   read_data_d = {24'h000000, crc_running_sum_q[15:8]};
      `CRC_ADDR_SELECT_A_CTRL:  read_data_d = {31'h00000000, select_a_q};
      `CRC_ADDR_SUM_WORD:   read_data_d = {16'h0000, crc_running_sum_q};
      default:              read_data_d = `CRC_UNMAPPED_DATA;
    endcase
  end

  always @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      AVS_READDATA_OUT <= `CRC_UNMAPPED_DATA;
      CRC_SUM_OUT      <= `CRC_SUM_RESET;
    end else begin
      if (rd_go) begin
        AVS_READDATA_OUT <= read_data_d;
      end
      CRC_SUM_OUT <= crc_running_sum_d;
    end
  end

endmodule

/* src/crc_byte_step.v */
`timescale 1ns/1ps
`include "crc_unit_defines.vh"

module crc_byte_step (
  input  wire [15:0] sum_in,
  input  wire [7:0]  data_in,
  input  wire        select_a_in,
  output wire [15:0] sum_out
);

  wire [15:0] select_a;
  wire [15:0] stage [0:8];

  assign select_a = (select_a_in == `CRC_SEL_CRC16) ? `CRC_SELECT_A_CRC16 : `CRC_SELECT_A_CCITT;

  assign stage[0] = sum_in ^ {data_in, 8'h00};

  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_bit
      // shift left, zero in; conditional XOR on bit leaving
      assign stage[i+1] = stage[i][15] ? ({stage[i][14:0], 1'b0} ^ select_a)
                                       : {stage[i][14:0], 1'b0};
    end
  endgenerate

  assign sum_out = stage[8];

endmodule

/* src/crc_unit_defines.vh */
`ifndef CRC_UNIT_DEFINES_VH
`define CRC_UNIT_DEFINES_VH

// Register word addresses (byte address = word index * 4)
`define CRC_ADDR_BYTE_INPUT   4'h0
`define CRC_ADDR_SUM_LOW      4'h1
`define CRC_ADDR_SUM_HIGH     4'h2
`define CRC_ADDR_SELECT_A_CTRL    4'h3
`define CRC_ADDR_SUM_WORD     4'h4

`define CRC_BYTE_RESET        8'h00
`define CRC_SUM_RESET         16'h0000
`define CRC_SELECT_A_SEL_RESET    1'b0
`define CRC_SELECT_A_SEL_BIT      0

`define CRC_SELECT_A_CCITT        16'h1021
`define CRC_SELECT_A_CRC16        16'h8005
`define CRC_SEL_CCITT         1'b0
`define CRC_SEL_CRC16         1'b1

`define CRC_UNMAPPED_DATA     32'h00000000

`endif
